// ---- rtl/uart_cfg_pkg.sv ----
// Constants and types for the serial format and interrupt control block
package uart_cfg_pkg;

	localparam int          ADDR_W        = 3;
	localparam int          DATA_W        = 16;

	// Word offsets on the register port
	localparam logic [2:0]  FMT_ADDR      = 3'h0;
	localparam logic [2:0]  CTRL_ADDR     = 3'h1;

	localparam logic [15:0] FMT_RESET     = 16'h0000;
	localparam logic [15:0] CTRL_RESET    = 16'h0000;
	// Writable bits; everything else is held at zero
	localparam logic [15:0] FMT_WMASK     = 16'h007b;
	localparam logic [15:0] CTRL_WMASK    = 16'h00fb;
	localparam logic [15:0] RD_IDLE       = 16'h0000;

	// Prescaler select codes and their counter masks
	localparam logic [1:0]  PRE_DIV1      = 2'b00;
	localparam logic [1:0]  PRE_DIV4      = 2'b01;
	localparam logic [1:0]  PRE_DIV16     = 2'b10;
	localparam logic [1:0]  PRE_DIV64     = 2'b11;
	localparam logic [5:0]  MASK_DIV1     = 6'h00;
	localparam logic [5:0]  MASK_DIV4     = 6'h03;
	localparam logic [5:0]  MASK_DIV16    = 6'h0f;
	localparam logic [5:0]  MASK_DIV64    = 6'h3f;
	localparam logic [5:0]  DIV_CNT_RESET = 6'h00;

	// Serial clock pin source codes
	localparam logic [1:0]  CLKSRC_PORT   = 2'b00;
	localparam logic [1:0]  CLKSRC_OUT    = 2'b01;

	localparam logic [7:0]  BYTE_RESET    = 8'h00;

	typedef struct packed {
		logic [8:0] rsvd_hi;
		logic       char7;
		logic       parity_en;
		logic       parity_odd;
		logic       two_stop;
		logic       rsvd_lo;
		logic [1:0] prescale;
	} fmt_t;

	typedef struct packed {
		logic [7:0] rsvd_hi;
		logic       tx_irq_enable;
		logic       rx_irq_enable;
		logic       transmit_enable;
		logic       rx_enable;
		logic       rx_fault_irq_enable;
		logic       rsvd_lo;
		logic [1:0] clock_source;
	} ctrl_t;

	typedef struct packed {
		logic tx_fifo_empty_flag;
		logic rx_fifo_full_flag;
		logic rx_timeout_flag;
		logic rx_fault_flag;
		logic line_break_flag;
		logic rx_overrun_flag;
	} flags_t;

	typedef struct packed {
		logic tx_empty_irq;
		logic rx_data_irq;
		logic rx_fault_irq;
		logic line_break_irq;
	} irq_t;

	localparam irq_t IRQ_RESET = '0;

endpackage

// ---- rtl/uart_format_and_irq_control.sv ----
// Format, control and interrupt request logic of a FIFO serial port
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Format register clears on reset only; standby leaves it intact.
// - Control register clears on reset only; standby leaves it intact.
// - Both registers are readable and writable at any time.
// - Format bits 15..7 read zero; software writes zero.
// - Format bit 6 selects seven data bits, dropping transmit bit 7.
// - Format bit 5 enables parity append on transmit and check on receive.
// - Format bit 4 picks odd parity; ignored while parity is off.
// - Parity makes data ones plus parity even or odd as chosen.
// - Format bit 3 chooses one or two stop bits on transmit.
// - Receiver checks the first stop bit only; low second slot is start.
// - Format bit 2 reads zero; software writes zero.
// - Format bits 1..0 divide the baud source by 1, 4, 16 or 64.
// - Control bits 15..8 and 2 read zero; software writes zero.
// - Transmit interrupt enable bit 7 raises the empty interrupt while its flag is set.
// - Empty interrupt drops when bit 7 clears or its flag is cleared.
// - Bit 6 enables data, fault and break interrupts from their flags.
// - Data interrupt drops when its flag clears or bit 6 clears.
// - Fault and break interrupts drop on flag clear or both enables clear.
// - With bit 5 set, transmission starts once transmit data is queued.
// - Clearing bit 4 stops new reception; receive flags keep their values.
// - Bit 3 enables fault and break interrupts even with bit 6 low.
// - Clock select: port, 16x clock out, or 16x clock in on the pin.
module uart_format_and_irq_control
	import uart_cfg_pkg::*;
(
	input  wire logic                      CLK_I,
	input  wire logic                      RESET_N_I,
	input  wire logic [uart_cfg_pkg::ADDR_W-1:0] ADDR_I,
	input  wire logic [uart_cfg_pkg::DATA_W-1:0] WR_DATA_I,
	input  wire logic                      WR_I,
	input  wire logic                      RD_I,
	output logic      [uart_cfg_pkg::DATA_W-1:0] RD_DATA_O,
	input  wire uart_cfg_pkg::flags_t      FLAGS_I,
	output uart_cfg_pkg::irq_t             IRQ_O,
	output uart_cfg_pkg::fmt_t             FORMAT_O,
	output uart_cfg_pkg::ctrl_t            CONTROL_O,
	output logic                           PRESCALE_TICK_O,
	input  wire logic [7:0]                TX_DATA_I,
	output logic      [7:0]                TX_BYTE_O,
	output logic                           TX_PARITY_O,
	input  wire logic                      TX_PENDING_I,
	output logic                           TX_LAUNCH_O,
	input  wire logic [7:0]                RX_DATA_I,
	input  wire logic                      RX_PARITY_I,
	input  wire logic                      RX_STOP1_I,
	output logic                           RX_PARITY_ERR_O,
	output logic                           RX_FRAME_ERR_O,
	input  wire logic                      RX_START_SEEN_I,
	output logic                           RX_LAUNCH_O,
	input  wire logic                      BRG_CLK16_I,
	input  wire logic                      SCK_I,
	output logic                           SCK_O,
	output logic                           SCK_OE_O,
	output logic                           EXT_CLK16_O,
	output logic                           CLK_EXTERNAL_O
);
	import uart_cfg_pkg::*;

	fmt_t        fmt;
	ctrl_t       ctrl;
	logic [5:0]  div_cnt;
	logic [15:0] next_rd_data;
	logic        fmt_wr;
	logic        ctrl_wr;
	logic [5:0]  div_mask;
	logic [7:0]  tx_eff;
	logic [7:0]  rx_eff;
	logic        next_tx_parity;
	logic        next_rx_parity_err;
	logic        rx_err_enable;
	irq_t        next_irq;
	logic        ext_src;

	// Ones count parity over the active data bits
	function automatic logic calc_parity(input logic [7:0] data, input logic odd);
		calc_parity = (^data) ^ odd;
	endfunction

	// Mask of the prescaler counter for a select code
	function automatic logic [5:0] div_mask_of(input logic [1:0] sel);
		logic [5:0] m;
		m = MASK_DIV1;
		case (sel)
			PRE_DIV4:  m = MASK_DIV4;
			PRE_DIV16: m = MASK_DIV16;
			PRE_DIV64: m = MASK_DIV64;
			default:   m = MASK_DIV1;
		endcase
		div_mask_of = m;
	endfunction

	assign fmt_wr  = WR_I && (ADDR_I == FMT_ADDR);
	assign ctrl_wr = WR_I && (ADDR_I == CTRL_ADDR);

	always_comb begin
		next_rd_data = RD_IDLE;
		if (RD_I && (ADDR_I == FMT_ADDR)) begin
			next_rd_data = fmt & FMT_WMASK;
		end else if (RD_I && (ADDR_I == CTRL_ADDR)) begin
			next_rd_data = ctrl & CTRL_WMASK;
		end else begin
			next_rd_data = RD_IDLE;
		end
	end

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			fmt <= FMT_RESET;
		end else if (fmt_wr) begin
			fmt <= WR_DATA_I & FMT_WMASK;
		end
	end

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			ctrl <= CTRL_RESET;
		end else if (ctrl_wr) begin
			ctrl <= WR_DATA_I & CTRL_WMASK;
		end
	end

	// free running divider, tick on masked zero
	assign div_mask = div_mask_of(fmt.prescale);

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			div_cnt         <= DIV_CNT_RESET;
			PRESCALE_TICK_O <= 1'b0;
		end else begin
			div_cnt         <= div_cnt + 6'h01;
			PRESCALE_TICK_O <= (div_cnt & div_mask) == DIV_CNT_RESET;
		end
	end

	// bit 7 dropped in seven bit mode
	assign tx_eff = fmt.char7 ? {1'b0, TX_DATA_I[6:0]} : TX_DATA_I;
	assign rx_eff = fmt.char7 ? {1'b0, RX_DATA_I[6:0]} : RX_DATA_I;

	assign next_tx_parity     = fmt.parity_en && calc_parity(tx_eff, fmt.parity_odd);
	assign next_rx_parity_err = fmt.parity_en &&
		(calc_parity(rx_eff, fmt.parity_odd) != RX_PARITY_I);

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			TX_BYTE_O       <= BYTE_RESET;
			TX_PARITY_O     <= 1'b0;
			RX_PARITY_ERR_O <= 1'b0;
			RX_FRAME_ERR_O  <= 1'b0;
		end else begin
			TX_BYTE_O       <= tx_eff;
			TX_PARITY_O     <= next_tx_parity;
			RX_PARITY_ERR_O <= next_rx_parity_err;
			RX_FRAME_ERR_O  <= !RX_STOP1_I;
		end
	end

	// fault path opens on either enable
	assign rx_err_enable = ctrl.rx_irq_enable || ctrl.rx_fault_irq_enable;

	assign next_irq.tx_empty_irq   = FLAGS_I.tx_fifo_empty_flag && ctrl.tx_irq_enable;
	assign next_irq.rx_data_irq    = (FLAGS_I.rx_fifo_full_flag || FLAGS_I.rx_timeout_flag)
		&& ctrl.rx_irq_enable;
	assign next_irq.rx_fault_irq   = FLAGS_I.rx_fault_flag && rx_err_enable;
	assign next_irq.line_break_irq = (FLAGS_I.line_break_flag || FLAGS_I.rx_overrun_flag)
		&& rx_err_enable;

	// high select bit forces external clock
	assign ext_src = ctrl.clock_source[1];

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			IRQ_O          <= IRQ_RESET;
			FORMAT_O       <= FMT_RESET;
			CONTROL_O      <= CTRL_RESET;
			RD_DATA_O      <= RD_IDLE;
			TX_LAUNCH_O    <= 1'b0;
			RX_LAUNCH_O    <= 1'b0;
			SCK_O          <= 1'b0;
			SCK_OE_O       <= 1'b0;
			EXT_CLK16_O    <= 1'b0;
			CLK_EXTERNAL_O <= 1'b0;
		end else begin
			IRQ_O          <= next_irq;
			FORMAT_O       <= fmt;
			CONTROL_O      <= ctrl;
			RD_DATA_O      <= next_rd_data;
			TX_LAUNCH_O    <= ctrl.transmit_enable && TX_PENDING_I;
			// gates starts; status flags live elsewhere
			RX_LAUNCH_O    <= ctrl.rx_enable && RX_START_SEEN_I;
			SCK_OE_O       <= (ctrl.clock_source == CLKSRC_OUT);
			SCK_O          <= (ctrl.clock_source == CLKSRC_OUT) && BRG_CLK16_I;
			EXT_CLK16_O    <= ext_src && SCK_I;
			CLK_EXTERNAL_O <= ext_src;
		end
	end

	// Checks kept next to the logic they guard

	sequence s_fmt_write;
		fmt_wr;
	endsequence

	property p_fmt_write;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		s_fmt_write |=> ##1 (FORMAT_O == ($past(WR_DATA_I, 2) & FMT_WMASK));
	endproperty
	a_fmt_write: assert property (p_fmt_write) else $error("format write not stored");

	property p_fmt_reserved;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		(RD_I && ADDR_I == FMT_ADDR) |=> (RD_DATA_O[15:7] == 9'h000) && !RD_DATA_O[2];
	endproperty
	a_fmt_reserved: assert property (p_fmt_reserved) else $error("format reserved bit set");

	property p_ctrl_readback;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		(RD_I && ADDR_I == CTRL_ADDR) |=>
			RD_DATA_O == ({8'h00, $past(ctrl[7:0])} & CTRL_WMASK);
	endproperty
	a_ctrl_readback: assert property (p_ctrl_readback) else $error("control readback wrong");

	property p_idle_read;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		!RD_I |=> RD_DATA_O == RD_IDLE;
	endproperty
	a_idle_read: assert property (p_idle_read) else $error("read data outside read slot");

	property p_seven_bit;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		fmt.char7 |=> !TX_BYTE_O[7];
	endproperty
	a_seven_bit: assert property (p_seven_bit) else $error("bit 7 sent in seven bit mode");

	property p_parity;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		fmt.parity_en |=> (^TX_BYTE_O ^ TX_PARITY_O) == $past(fmt.parity_odd);
	endproperty
	a_parity: assert property (p_parity) else $error("parity sense wrong");

	property p_parity_off;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		!fmt.parity_en |=> !TX_PARITY_O && !RX_PARITY_ERR_O;
	endproperty
	a_parity_off: assert property (p_parity_off) else $error("parity active while off");

	property p_stop_check;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		RX_STOP1_I |=> !RX_FRAME_ERR_O;
	endproperty
	a_stop_check: assert property (p_stop_check) else $error("framing error on good stop");

	// Tick made under an older code has a different phase
	sequence s_div4_run;
		(PRESCALE_TICK_O && fmt.prescale == PRE_DIV4 && $past(fmt.prescale) == PRE_DIV4)
			##1 (fmt.prescale == PRE_DIV4) [*3];
	endsequence

	property p_div4;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		s_div4_run |=> PRESCALE_TICK_O;
	endproperty
	a_div4: assert property (p_div4) else $error("divide by 4 period wrong");

	property p_div4_gap;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		(PRESCALE_TICK_O && fmt.prescale == PRE_DIV4 && $past(fmt.prescale) == PRE_DIV4
			&& !fmt_wr) |=> !PRESCALE_TICK_O;
	endproperty
	a_div4_gap: assert property (p_div4_gap) else $error("divide by 4 ticks too soon");

	property p_tx_irq_off;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		!ctrl.tx_irq_enable |=> !IRQ_O.tx_empty_irq;
	endproperty
	a_tx_irq_off: assert property (p_tx_irq_off) else $error("empty irq while disabled");

	property p_tx_irq_on;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		(ctrl.tx_irq_enable && FLAGS_I.tx_fifo_empty_flag) |=> IRQ_O.tx_empty_irq;
	endproperty
	a_tx_irq_on: assert property (p_tx_irq_on) else $error("empty irq missing");

	property p_rx_data_irq;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		1'b1 |=> IRQ_O.rx_data_irq == ($past(ctrl.rx_irq_enable) &&
			($past(FLAGS_I.rx_fifo_full_flag) || $past(FLAGS_I.rx_timeout_flag)));
	endproperty
	a_rx_data_irq: assert property (p_rx_data_irq) else $error("data irq wrong");

	property p_fault_dma;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		(ctrl.rx_fault_irq_enable && !ctrl.rx_irq_enable && FLAGS_I.rx_overrun_flag)
			|=> IRQ_O.line_break_irq && !IRQ_O.rx_data_irq;
	endproperty
	a_fault_dma: assert property (p_fault_dma) else $error("break irq missing via bit 3");

	property p_fault_off;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		!rx_err_enable |=> !IRQ_O.rx_fault_irq && !IRQ_O.line_break_irq;
	endproperty
	a_fault_off: assert property (p_fault_off) else $error("fault irq while disabled");

	property p_sck_pin;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		ext_src |=> !SCK_OE_O && CLK_EXTERNAL_O;
	endproperty
	a_sck_pin: assert property (p_sck_pin) else $error("pin driven with external clock");

	property p_tx_launch;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		!ctrl.transmit_enable |=> !TX_LAUNCH_O;
	endproperty
	a_tx_launch: assert property (p_tx_launch) else $error("transmit launch while off");

	property p_rx_launch;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		!ctrl.rx_enable |=> !RX_LAUNCH_O;
	endproperty
	a_rx_launch: assert property (p_rx_launch) else $error("receive launch while off");

	property p_stop_count;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		fmt_wr |=> fmt.two_stop == $past(WR_DATA_I[3]);
	endproperty
	a_stop_count: assert property (p_stop_count) else $error("stop count not stored");

	property p_ctrl_write;
		@(posedge CLK_I) disable iff (!RESET_N_I)
		ctrl_wr |=> ctrl == ($past(WR_DATA_I) & CTRL_WMASK);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write not stored");

endmodule

`default_nettype wire

// ---- test/uart_format_and_irq_control_bench.sv ----
// Self-checking bench for the serial format and interrupt control block
`timescale 1ns/1ps
`default_nettype none
module uart_format_and_irq_control_bench;
	import uart_cfg_pkg::*;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [2:0]  addr = 3'h0;
	logic [15:0] wdata = 16'h0000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [15:0] rdata;
	flags_t      flags = '0;
	irq_t        irq;
	fmt_t        fmt;
	ctrl_t       ctrl;
	logic        tick, txpar, txl, rperr, rferr, rxl, sck_o, sck_oe, ext16, ext_sel;
	logic [7:0]  txd = 8'h00;
	logic [7:0]  txb;
	logic        pend = 1'b0;
	logic        brg = 1'b0;
	logic        run = 1'b0;
	logic [7:0]  rxd;
	logic        rxp, stop1, start, sck_i;
	int          failures = 0;
	int          num_checks = 0;
	int          cnt;
	logic [15:0] v, fv, cv;

	always #2 clk = ~clk;

	uart_format_and_irq_control dut_u (
		.CLK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr), .WR_DATA_I(wdata), .WR_I(wr),
		.RD_I(rd), .RD_DATA_O(rdata), .FLAGS_I(flags), .IRQ_O(irq), .FORMAT_O(fmt),
		.CONTROL_O(ctrl), .PRESCALE_TICK_O(tick), .TX_DATA_I(txd), .TX_BYTE_O(txb),
		.TX_PARITY_O(txpar), .TX_PENDING_I(pend), .TX_LAUNCH_O(txl), .RX_DATA_I(rxd),
		.RX_PARITY_I(rxp), .RX_STOP1_I(stop1), .RX_PARITY_ERR_O(rperr),
		.RX_FRAME_ERR_O(rferr), .RX_START_SEEN_I(start), .RX_LAUNCH_O(rxl),
		.BRG_CLK16_I(brg), .SCK_I(sck_i), .SCK_O(sck_o), .SCK_OE_O(sck_oe),
		.EXT_CLK16_O(ext16), .CLK_EXTERNAL_O(ext_sel)
	);

	uart_remote_peer peer_u (
		.clk_i(clk), .run_i(run), .fmt_i(fmt), .rx_data_o(rxd), .rx_parity_o(rxp),
		.rx_stop1_o(stop1), .rx_start_o(start), .sck_o(sck_i)
	);

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	task automatic close_out();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	function automatic irq_t exp_irq(input flags_t f, input ctrl_t c);
		logic rx_any;
		irq_t r;
		rx_any = c.rx_irq_enable | c.rx_fault_irq_enable;
		r.tx_empty_irq = f.tx_fifo_empty_flag & c.tx_irq_enable;
		r.rx_data_irq = (f.rx_fifo_full_flag | f.rx_timeout_flag) & c.rx_irq_enable;
		r.rx_fault_irq = f.rx_fault_flag & rx_any;
		r.line_break_irq = (f.line_break_flag | f.rx_overrun_flag) & rx_any;
		return r;
	endfunction

	// Parity bit that makes the character plus parity even or odd
	function automatic logic par(input logic [7:0] d, input fmt_t f);
		return f.parity_en & ((^(f.char7 ? {1'b0, d[6:0]} : d)) ^ f.parity_odd);
	endfunction

	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		close_out();
	end

	initial begin
		void'($urandom(52101));
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rd_reg(FMT_ADDR, v);
		check(v, FMT_RESET);
		rd_reg(CTRL_ADDR, v);
		check(v, CTRL_RESET);
		// All-ones first, reserved bits must read back zero
		for (int i = 0; i < 24; i++) begin
			v = (i == 0) ? 16'hffff : 16'($urandom);
			wr_reg(FMT_ADDR, v);
			wr_reg(CTRL_ADDR, ~v);
			wr_reg(3'h2 + 3'(i % 6), 16'hffff);
			rd_reg(FMT_ADDR, fv);
			check(fv, v & FMT_WMASK);
			rd_reg(CTRL_ADDR, cv);
			check(cv, ~v & CTRL_WMASK);
			rd_reg(3'h2 + 3'(i % 6), fv);
			check(fv, 16'h0000);
		end
		// Each prescale code over a window that all periods divide
		for (int p = 0; p < 4; p++) begin
			wr_reg(FMT_ADDR, 16'(p));
			repeat (4) @(posedge clk);
			cnt = 0;
			repeat (64) begin
				@(posedge clk);
				#1;
				cnt += (tick === 1'b1) ? 1 : 0;
			end
			check(16'(cnt), 16'(64 >> (2 * p)));
		end
		for (int i = 0; i < 200; i++) begin
			fv = 16'($urandom) & FMT_WMASK;
			cv = 16'($urandom) & CTRL_WMASK;
			wr_reg(FMT_ADDR, fv);
			wr_reg(CTRL_ADDR, cv);
			@(posedge clk);
			flags <= flags_t'($urandom);
			txd <= 8'($urandom);
			pend <= 1'($urandom);
			brg <= 1'($urandom);
			run <= 1'b1;
			@(posedge clk);
			run <= 1'b0;
			@(posedge clk);
			#1;
			check(16'(fmt), fv);
			check(16'(ctrl), cv);
			check(16'(irq), 16'(exp_irq(flags, ctrl_t'(cv))));
			check(16'(txb), 16'(fv[6] ? {1'b0, txd[6:0]} : txd));
			check(16'(txpar), 16'(par(txd, fmt_t'(fv))));
			check(16'(rperr), 16'(par(rxd, fmt_t'(fv)) ^ (rxp & fv[5])));
			check(16'(rferr), 16'(!stop1));
			check(16'(txl), 16'(cv[5] & pend));
			check(16'(rxl), 16'(cv[4] & start));
			check(16'(sck_oe), 16'(cv[1:0] == CLKSRC_OUT));
			check(16'(ext16), 16'(cv[1] & sck_i));
			check(16'(ext_sel), 16'(cv[1]));
			if (cv[1:0] == CLKSRC_OUT) begin
				check(16'(sck_o), 16'(brg));
			end
		end
		// Second reset in mid-run must clear both registers
		wr_reg(FMT_ADDR, FMT_WMASK);
		@(posedge clk);
		rst_n <= 1'b0;
		@(posedge clk);
		rst_n <= 1'b1;
		rd_reg(FMT_ADDR, v);
		check(v, FMT_RESET);
		rd_reg(CTRL_ADDR, v);
		check(v, CTRL_RESET);
		close_out();
	end
endmodule
`default_nettype wire

// ---- test/uart_remote_peer.sv ----
// Far-end transceiver model feeding received characters and the pin clock
`timescale 1ns/1ps
`default_nettype none
module uart_remote_peer
	import uart_cfg_pkg::*;
(
	input  wire logic               clk_i,
	input  wire logic               run_i,
	input  wire uart_cfg_pkg::fmt_t fmt_i,
	output logic [7:0]              rx_data_o,
	output logic                    rx_parity_o,
	output logic                    rx_stop1_o,
	output logic                    rx_start_o,
	output logic                    sck_o
);
	logic [7:0] chr;
	logic [2:0] roll;

	initial begin
		rx_data_o = 8'h00;
		rx_parity_o = 1'b0;
		rx_stop1_o = 1'b1;
		rx_start_o = 1'b0;
		sck_o = 1'b0;
	end

	// Holds every line steady between steps so the bench can sample them
	always @(posedge clk_i) begin
		if (run_i) begin
			chr = 8'($urandom);
			roll = 3'($urandom);
			rx_data_o <= chr;
			// sender parity, corrupted on one roll value in eight while parity is enabled
			rx_parity_o <= fmt_i.parity_en & ((^(fmt_i.char7 ? {1'b0, chr[6:0]} : chr))
				^ fmt_i.parity_odd ^ (roll == 3'h0));
			// first stop bit high except on an injected framing fault
			rx_stop1_o <= (roll != 3'h1);
			rx_start_o <= roll[2];
			// external 16x clock from the far side
			sck_o <= ~sck_o;
		end
	end
endmodule
`default_nettype wire
